// ---- src/fsc_pkg.sv ----
package fsc_pkg;
	localparam int CLK_MHZ = 125;
	localparam int UNIT_US = 500;
	localparam int UNIT_CYC = UNIT_US * CLK_MHZ;
	localparam int STEP_W_NS = 1000;
	localparam int STEP_W_CYC = (STEP_W_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] ADDR_SPECIFY = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_PERP = 8'h08;
	localparam logic [7:0] ADDR_RATE = 8'h0C;
	localparam logic [7:0] ADDR_POSITION = 8'h10;
	localparam logic [7:0] ADDR_SENSE = 8'h14;
	localparam logic [7:0] ADDR_DRV_STAT = 8'h18;
	localparam logic [7:0] ADDR_VERSION = 8'h1C;
	localparam int SPEC_STEP_LSB = 0;
	localparam int SPEC_UNLOAD_LSB = 4;
	localparam int SPEC_LOAD_LSB = 8;
	localparam int SPEC_NODMA_BIT = 15;
	localparam int CFG_IMPLIED_BIT = 0;
	localparam int CFG_FIFO_DIS_BIT = 1;
	localparam int CFG_POLL_DIS_BIT = 2;
	localparam int CFG_THR_LSB = 4;
	localparam int CFG_PRECOMP_LSB = 8;
	localparam int PERP_GAP_BIT = 0;
	localparam int PERP_WRITE_GATE_BIT = 1;
	localparam int PERP_GAP2_LSB = 8;
	localparam int PERP_WRITTEN_LSB = 16;
	localparam int POS_TARGET_LSB = 0;
	localparam int POS_DRIVE_BIT = 8;
	localparam int POS_OP_LSB = 12;
	localparam int POS_DIR_BIT = 14;
	localparam int POS_BUSY_LSB = 16;
	localparam int POS_REL_BIT = 18;
	localparam int SBZ_CODE_LSB = 6;
	localparam int SBZ_SEEK_END_BIT = 5;
	localparam int SBZ_EQUIP_BIT = 4;
	localparam int SBZ_HEAD_BIT = 2;
	localparam int ST3_WP_BIT = 6;
	localparam int ST3_RDY_BIT = 5;
	localparam int ST3_TR0_BIT = 4;
	localparam int ST3_TS_BIT = 3;
	localparam logic [3:0] SPEC_STEP_RST = 4'h0;
	localparam logic [3:0] SPEC_UNLOAD_RST = 4'h0;
	localparam logic [6:0] SPEC_LOAD_RST = 7'h00;
	localparam logic SPEC_NODMA_RST = 1'b0;
	localparam logic CFG_IMPLIED_RST = 1'b0;
	localparam logic CFG_FIFO_DIS_RST = 1'b1;
	localparam logic CFG_POLL_DIS_RST = 1'b0;
	localparam logic [3:0] CFG_THR_RST = 4'h0;
	localparam logic [7:0] CFG_PRECOMP_RST = 8'h00;
	localparam logic PERP_BIT_RST = 1'b0;
	localparam logic [1:0] RATE_RST = 2'h0;
	localparam logic [1:0] CODE_NORMAL = 2'h0;
	localparam logic [1:0] CODE_ABNORMAL = 2'h1;
	localparam logic [1:0] CODE_INVALID = 2'h2;
	localparam logic [1:0] CODE_POLL = 2'h3;
	localparam logic [5:0] GAP2_CONV = 6'h16;
	localparam logic [5:0] GAP2_PERP_1M = 6'h29;
	localparam logic [5:0] WRITTEN_CONV = 6'h00;
	localparam logic [5:0] WRITTEN_500K = 6'h13;
	localparam logic [5:0] WRITTEN_1M = 6'h26;
	localparam logic [7:0] RECAL_MAX = 8'h50;
	localparam logic [4:0] STEP_ZERO_UNITS = 5'h10;
	localparam logic [11:0] UNLOAD_UNITS = 12'h010;
	localparam logic [11:0] LOAD_UNITS = 12'h002;
	localparam logic [11:0] HEAD_ZERO_CODE = 12'h080;
	localparam logic [6:0] UNLOAD_ZERO_CODE = 7'h10;
	localparam logic [1:0] RATE_500K = 2'h0;
	localparam logic [1:0] RATE_300K = 2'h1;
	localparam logic [1:0] RATE_250K = 2'h2;
	localparam logic [1:0] RATE_1M = 2'h3;
	typedef enum logic [1:0] {OP_NONE, OP_SEEK, OP_REL, OP_RECAL} fsc_op_t;
	typedef enum logic [2:0] {RW_IDLE, RW_SEEK, RW_WAIT, RW_LOAD, RW_RUN, RW_UNLOAD} fsc_rw_t;
endpackage

// ---- src/fsc_seek_config.sv ----
`timescale 1ns/1ps
module fsc_seek_config import fsc_pkg::*; #(
	parameter int UNIT_CYCLES = UNIT_CYC,
	parameter logic [7:0] VERSION_ID = 8'h5A // Arbitrary value
) (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Async reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [1:0] drv_track0, // Head at track zero
	input wire logic [1:0] drv_write_protect, // Media protected
	input wire logic [1:0] drv_ready, // Drive ready
	input wire logic [1:0] drv_two_side, // Two-sided drive
	output logic [1:0] step_out, // Step pulse per drive
	output logic [1:0] dir_out, // Direction, 1 steps in
	output logic head_load, // Head load
	input wire logic rw_start, // Read/write request
	input wire logic rw_drive, // Drive of request
	input wire logic [7:0] rw_cylinder, // Cylinder of request
	output logic rw_go, // Data phase may start
	input wire logic rw_end, // Data phase finished
	input wire logic [4:0] fifo_level, // Bytes waiting
	output logic dma_request_pin, // DMA request
	output logic request_for_master, // Host request flag
	output logic interrupt_pin, // Interrupt
	output logic [5:0] gap2_length // Gap2 field bytes
);
	logic [3:0] step_rate_delay_ff, head_unload_delay_ff;
	logic [6:0] head_load_delay_ff;
	logic no_dma_select_ff, implied_seek_enable_ff, fifo_disable_option_ff, poll_dis_ff;
	logic [3:0] fifo_threshold_ff;
	logic [7:0] precomp_start_track_ff;
	logic gap_bit_ff, write_gate_timing_bit_ff, dsel_ff;
	logic [1:0] rate_ff;
	logic [31:0] prdata_ff, rdata;
	logic pready_ff, pslverr_ff, pos_ok_ff;
	logic [1:0] sense_sel_ff;
	logic [31:0] presc_ff;
	logic tick_ff;
	logic [7:0] present_cylinder_ff [2];
	logic [7:0] cnt_ff [2];
	logic [4:0] stimer_ff [2];
	logic [7:0] sw_ff [2];
	logic [1:0] code_ff [2];
	fsc_op_t op_ff [2];
	fsc_op_t start_op [2];
	logic [1:0] busy_ff, pend_ff, equip_ff, quiet_ff, step_ff, dir_ff;
	fsc_rw_t rw_ff;
	logic rw_drv_ff, head_load_ff, rw_go_ff;
	logic [7:0] rw_cyl_ff;
	logic [11:0] dtimer_ff;
	logic poll_wait_ff, poll_irq_ff;
	logic dma_ff, host_req_ff, irq_ff;
	logic [5:0] gap2_ff, gap2, written;
	logic setup, access, wr_acc, pos_go, rel_active, rw_seek_go, xfer;
	logic start_dir, start_quiet, pw_drive, pos_ok, bad;
	fsc_op_t pw_op;
	logic [7:0] start_arg, sbz, sense_cyl;
	logic [1:0] sense_sel;

	function automatic logic [31:0] unit_limit(input logic [1:0] rate);
		case (rate)
			RATE_1M: unit_limit = 32'(UNIT_CYCLES);
			RATE_300K: unit_limit = 32'((UNIT_CYCLES * 10) / 3);
			RATE_250K: unit_limit = 32'(UNIT_CYCLES * 4);
			default: unit_limit = 32'(UNIT_CYCLES * 2);
		endcase
	endfunction

	function automatic logic [11:0] head_units(input logic [6:0] code, input logic [11:0] mult);
		head_units = 12'((code == 7'h00 ? HEAD_ZERO_CODE : {5'h00, code}) * mult);
	endfunction

	function automatic logic xfer_wanted(input logic [4:0] level, input logic dis,
		input logic [3:0] thr);
		xfer_wanted = dis ? (level != 5'h00) : (level > {1'b0, thr});
	endfunction

	function automatic logic [7:0] status_zero(input logic [1:0] code, input logic seek_end,
		input logic equip, input logic drv);
		status_zero = 8'h00;
		status_zero[SBZ_CODE_LSB +: 2] = code;
		status_zero[SBZ_SEEK_END_BIT] = seek_end;
		status_zero[SBZ_EQUIP_BIT] = equip;
		status_zero[SBZ_HEAD_BIT] = 1'b0;
		status_zero[0] = drv;
	endfunction

	assign setup = psel && !penable;
	assign access = psel && penable && pready_ff;
	assign wr_acc = access && pwrite && !pslverr_ff;
	assign pw_drive = pwdata[POS_DRIVE_BIT];
	assign pw_op = fsc_op_t'(pwdata[POS_OP_LSB +: 2]);
	assign rel_active = (op_ff[0] == OP_REL) || (op_ff[1] == OP_REL);
	assign pos_ok = pw_op != OP_NONE && !busy_ff[pw_drive]
		&& !(pw_op == OP_REL && rel_active)
		&& !(rw_ff != RW_IDLE && rw_drv_ff == pw_drive);
	assign pos_go = wr_acc && paddr == ADDR_POSITION && pos_ok_ff;
	assign rw_seek_go = rw_ff == RW_SEEK && !pos_go && !busy_ff[rw_drv_ff]
		&& op_ff[rw_drv_ff] == OP_NONE;
	assign xfer = rw_ff == RW_RUN
		&& xfer_wanted(fifo_level, fifo_disable_option_ff, fifo_threshold_ff);
	assign gap2 = (gap_bit_ff && write_gate_timing_bit_ff) ? GAP2_PERP_1M : GAP2_CONV;
	assign written = !gap_bit_ff ? WRITTEN_CONV
		: (write_gate_timing_bit_ff ? WRITTEN_1M : WRITTEN_500K);

	always_comb begin
		start_dir = pwdata[POS_DIR_BIT];
		start_arg = pwdata[POS_TARGET_LSB +: 8];
		start_quiet = 1'b0;
		start_op[0] = OP_NONE;
		start_op[1] = OP_NONE;
		if (pos_go) begin
			start_op[pw_drive] = pw_op;
		end else if (rw_seek_go) begin
			start_op[rw_drv_ff] = OP_SEEK;
			start_arg = rw_cyl_ff;
			start_quiet = 1'b1;
		end
	end

	// Sense picks polling first, then drive 0, then drive 1
	always_comb begin
		sense_sel = 2'h0;
		sbz = status_zero(CODE_INVALID, 1'b0, 1'b0, 1'b0);
		sense_cyl = 8'h00;
		if (poll_irq_ff) begin
			sense_sel = 2'h1;
			sbz = status_zero(CODE_POLL, 1'b0, 1'b0, 1'b0);
		end else if (pend_ff[0] || pend_ff[1]) begin
			sense_sel = pend_ff[0] ? 2'h2 : 2'h3;
			sbz = status_zero(code_ff[sense_sel[0]], 1'b1, equip_ff[sense_sel[0]], sense_sel[0]);
			sense_cyl = present_cylinder_ff[sense_sel[0]];
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		bad = 1'b0;
		case (paddr)
			ADDR_SPECIFY: begin
				rdata[SPEC_STEP_LSB +: 4] = step_rate_delay_ff;
				rdata[SPEC_UNLOAD_LSB +: 4] = head_unload_delay_ff;
				rdata[SPEC_LOAD_LSB +: 7] = head_load_delay_ff;
				rdata[SPEC_NODMA_BIT] = no_dma_select_ff;
			end
			ADDR_CONFIG: begin
				rdata[CFG_IMPLIED_BIT] = implied_seek_enable_ff;
				rdata[CFG_FIFO_DIS_BIT] = fifo_disable_option_ff;
				rdata[CFG_POLL_DIS_BIT] = poll_dis_ff;
				rdata[CFG_THR_LSB +: 4] = fifo_threshold_ff;
				rdata[CFG_PRECOMP_LSB +: 8] = precomp_start_track_ff;
			end
			ADDR_PERP: begin
				rdata[PERP_GAP_BIT] = gap_bit_ff;
				rdata[PERP_WRITE_GATE_BIT] = write_gate_timing_bit_ff;
				rdata[PERP_GAP2_LSB +: 6] = gap2;
				rdata[PERP_WRITTEN_LSB +: 6] = written;
			end
			ADDR_RATE: rdata[1:0] = rate_ff;
			ADDR_POSITION: begin
				rdata[7:0] = present_cylinder_ff[0];
				rdata[15:8] = present_cylinder_ff[1];
				rdata[POS_BUSY_LSB +: 2] = busy_ff;
				rdata[POS_REL_BIT] = rel_active;
				bad = pwrite && !pos_ok;
			end
			ADDR_SENSE: begin
				rdata[15:0] = {sense_cyl, sbz};
				bad = pwrite;
			end
			ADDR_DRV_STAT: begin
				rdata[ST3_WP_BIT] = drv_write_protect[dsel_ff];
				rdata[ST3_RDY_BIT] = drv_ready[dsel_ff];
				rdata[ST3_TR0_BIT] = drv_track0[dsel_ff];
				rdata[ST3_TS_BIT] = drv_two_side[dsel_ff];
				rdata[0] = dsel_ff;
			end
			ADDR_VERSION: begin
				rdata[7:0] = VERSION_ID;
				bad = pwrite;
			end
			default: bad = 1'b1;
		endcase
	end

	// APB slave: answers one cycle after setup
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pos_ok_ff <= 1'b0;
			sense_sel_ff <= 2'h0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && bad;
			prdata_ff <= (setup && !pwrite) ? rdata : 32'h0000_0000;
			pos_ok_ff <= setup && pos_ok;
			sense_sel_ff <= (setup && !pwrite && paddr == ADDR_SENSE) ? sense_sel : 2'h0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			step_rate_delay_ff <= SPEC_STEP_RST;
			head_unload_delay_ff <= SPEC_UNLOAD_RST;
			head_load_delay_ff <= SPEC_LOAD_RST;
			no_dma_select_ff <= SPEC_NODMA_RST;
			implied_seek_enable_ff <= CFG_IMPLIED_RST;
			fifo_disable_option_ff <= CFG_FIFO_DIS_RST;
			poll_dis_ff <= CFG_POLL_DIS_RST;
			fifo_threshold_ff <= CFG_THR_RST;
			precomp_start_track_ff <= CFG_PRECOMP_RST;
			gap_bit_ff <= PERP_BIT_RST;
			write_gate_timing_bit_ff <= PERP_BIT_RST;
			rate_ff <= RATE_RST;
			dsel_ff <= 1'b0;
		end else if (wr_acc) begin
			case (paddr)
				ADDR_SPECIFY: begin
					step_rate_delay_ff <= pwdata[SPEC_STEP_LSB +: 4];
					head_unload_delay_ff <= pwdata[SPEC_UNLOAD_LSB +: 4];
					head_load_delay_ff <= pwdata[SPEC_LOAD_LSB +: 7];
					no_dma_select_ff <= pwdata[SPEC_NODMA_BIT];
				end
				ADDR_CONFIG: begin
					implied_seek_enable_ff <= pwdata[CFG_IMPLIED_BIT];
					fifo_disable_option_ff <= pwdata[CFG_FIFO_DIS_BIT];
					poll_dis_ff <= pwdata[CFG_POLL_DIS_BIT];
					fifo_threshold_ff <= pwdata[CFG_THR_LSB +: 4];
					precomp_start_track_ff <= pwdata[CFG_PRECOMP_LSB +: 8];
				end
				ADDR_PERP: begin
					gap_bit_ff <= pwdata[PERP_GAP_BIT];
					write_gate_timing_bit_ff <= pwdata[PERP_WRITE_GATE_BIT];
				end
				ADDR_RATE: rate_ff <= pwdata[1:0];
				ADDR_DRV_STAT: dsel_ff <= pwdata[0];
				default: dsel_ff <= dsel_ff;
			endcase
		end
	end

	// Timebase: one unit is 0.5 ms at 1 Mbps, stretched at slower rates
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			presc_ff <= 32'h0000_0000;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= presc_ff >= unit_limit(rate_ff) - 32'h0000_0001;
			presc_ff <= (presc_ff >= unit_limit(rate_ff) - 32'h0000_0001) ? 32'h0000_0000
				: presc_ff + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int d = 0; d < 2; d++) begin
				present_cylinder_ff[d] <= 8'h00;
				cnt_ff[d] <= 8'h00;
				stimer_ff[d] <= 5'h00;
				sw_ff[d] <= 8'h00;
				code_ff[d] <= CODE_NORMAL;
				op_ff[d] <= OP_NONE;
			end
			busy_ff <= 2'h0;
			pend_ff <= 2'h0;
			equip_ff <= 2'h0;
			quiet_ff <= 2'h0;
			step_ff <= 2'h0;
			dir_ff <= 2'h0;
		end else begin
			for (int d = 0; d < 2; d++) begin
				if (sw_ff[d] != 8'h00)
					sw_ff[d] <= sw_ff[d] - 8'h01;
				if (sw_ff[d] == 8'h01)
					step_ff[d] <= 1'b0;
				if (tick_ff && stimer_ff[d] != 5'h00)
					stimer_ff[d] <= stimer_ff[d] - 5'h01;
				if (sense_sel_ff == {1'b1, 1'(d)} && access) begin
					pend_ff[d] <= 1'b0;
					busy_ff[d] <= 1'b0;
				end
				if (start_op[d] != OP_NONE) begin
					op_ff[d] <= start_op[d];
					busy_ff[d] <= !start_quiet;
					quiet_ff[d] <= start_quiet;
					cnt_ff[d] <= start_op[d] == OP_RECAL ? 8'h00 : start_arg;
					dir_ff[d] <= start_op[d] == OP_REL ? start_dir : 1'b0;
					stimer_ff[d] <= 5'h00;
					equip_ff[d] <= 1'b0;
					if (start_op[d] == OP_RECAL)
						present_cylinder_ff[d] <= 8'h00;
				end else if (op_ff[d] != OP_NONE && sw_ff[d] == 8'h00 && stimer_ff[d] == 5'h00) begin
					case (op_ff[d])
						OP_SEEK: begin
							if (present_cylinder_ff[d] == cnt_ff[d]) begin
								op_ff[d] <= OP_NONE;
								code_ff[d] <= CODE_NORMAL;
								pend_ff[d] <= !quiet_ff[d];
							end else begin
								dir_ff[d] <= cnt_ff[d] > present_cylinder_ff[d];
								present_cylinder_ff[d] <= cnt_ff[d] > present_cylinder_ff[d]
									? present_cylinder_ff[d] + 8'h01 : present_cylinder_ff[d] - 8'h01;
								step_ff[d] <= 1'b1;
								sw_ff[d] <= 8'(STEP_W_CYC);
								stimer_ff[d] <= STEP_ZERO_UNITS - {1'b0, step_rate_delay_ff};
							end
						end
						OP_REL: begin
							if (cnt_ff[d] == 8'h00) begin
								op_ff[d] <= OP_NONE;
								code_ff[d] <= CODE_NORMAL;
								pend_ff[d] <= 1'b1;
							end else if (!dir_ff[d] && drv_track0[d]) begin
								op_ff[d] <= OP_NONE;
								code_ff[d] <= CODE_ABNORMAL;
								equip_ff[d] <= 1'b1;
								pend_ff[d] <= 1'b1;
							end else begin
								present_cylinder_ff[d] <= dir_ff[d] ? present_cylinder_ff[d] + 8'h01
									: present_cylinder_ff[d] - 8'h01;
								cnt_ff[d] <= cnt_ff[d] - 8'h01;
								step_ff[d] <= 1'b1;
								sw_ff[d] <= 8'(STEP_W_CYC);
								stimer_ff[d] <= STEP_ZERO_UNITS - {1'b0, step_rate_delay_ff};
							end
						end
						OP_RECAL: begin
							if (drv_track0[d]) begin
								op_ff[d] <= OP_NONE;
								code_ff[d] <= CODE_NORMAL;
								present_cylinder_ff[d] <= 8'h00;
								pend_ff[d] <= 1'b1;
							end else if (cnt_ff[d] == RECAL_MAX) begin
								op_ff[d] <= OP_NONE;
								code_ff[d] <= CODE_ABNORMAL;
								equip_ff[d] <= 1'b1;
								pend_ff[d] <= 1'b1;
							end else begin
								cnt_ff[d] <= cnt_ff[d] + 8'h01;
								step_ff[d] <= 1'b1;
								sw_ff[d] <= 8'(STEP_W_CYC);
								stimer_ff[d] <= STEP_ZERO_UNITS - {1'b0, step_rate_delay_ff};
							end
						end
						default: op_ff[d] <= OP_NONE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rw_ff <= RW_IDLE;
			rw_drv_ff <= 1'b0;
			rw_cyl_ff <= 8'h00;
			head_load_ff <= 1'b0;
			rw_go_ff <= 1'b0;
			dtimer_ff <= 12'h000;
		end else begin
			rw_go_ff <= 1'b0;
			if (tick_ff && dtimer_ff != 12'h000)
				dtimer_ff <= dtimer_ff - 12'h001;
			case (rw_ff)
				RW_IDLE, RW_UNLOAD: begin
					if (rw_start) begin
						rw_drv_ff <= rw_drive;
						rw_cyl_ff <= rw_cylinder;
						if (implied_seek_enable_ff && present_cylinder_ff[rw_drive] != rw_cylinder) begin
							rw_ff <= RW_SEEK;
						end else begin
							head_load_ff <= 1'b1;
							dtimer_ff <= head_units(head_load_delay_ff, LOAD_UNITS);
							rw_ff <= RW_LOAD;
						end
					end else if (rw_ff == RW_UNLOAD && dtimer_ff == 12'h000) begin
						head_load_ff <= 1'b0;
						rw_ff <= RW_IDLE;
					end
				end
				RW_SEEK: if (rw_seek_go)
					rw_ff <= RW_WAIT;
				RW_WAIT: if (op_ff[rw_drv_ff] == OP_NONE) begin
					head_load_ff <= 1'b1;
					dtimer_ff <= head_units(head_load_delay_ff, LOAD_UNITS);
					rw_ff <= RW_LOAD;
				end
				RW_LOAD: if (dtimer_ff == 12'h000) begin
					rw_go_ff <= 1'b1;
					rw_ff <= RW_RUN;
				end
				RW_RUN: if (rw_end) begin
					dtimer_ff <= head_units(head_unload_delay_ff == 4'h0 ? UNLOAD_ZERO_CODE
						: {3'h0, head_unload_delay_ff}, UNLOAD_UNITS);
					rw_ff <= RW_UNLOAD;
				end
				default: rw_ff <= RW_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			poll_wait_ff <= 1'b1;
			poll_irq_ff <= 1'b0;
			dma_ff <= 1'b0;
			host_req_ff <= 1'b0;
			irq_ff <= 1'b0;
			gap2_ff <= GAP2_CONV;
		end else begin
			if (poll_dis_ff) begin
				poll_wait_ff <= 1'b0;
			end else if (poll_wait_ff && !head_load_ff) begin
				poll_wait_ff <= 1'b0;
				poll_irq_ff <= 1'b1;
			end else if (sense_sel_ff == 2'h1 && access) begin
				poll_irq_ff <= 1'b0;
			end
			dma_ff <= !no_dma_select_ff && xfer;
			host_req_ff <= no_dma_select_ff && xfer;
			irq_ff <= poll_irq_ff || pend_ff != 2'h0 || (no_dma_select_ff && xfer);
			gap2_ff <= gap2;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign step_out = step_ff;
	assign dir_out = dir_ff;
	assign head_load = head_load_ff;
	assign rw_go = rw_go_ff;
	assign dma_request_pin = dma_ff;
	assign request_for_master = host_req_ff;
	assign interrupt_pin = irq_ff;
	assign gap2_length = gap2_ff;
endmodule

// ---- verif/fsc_drive_model.sv ----
`timescale 1ns/1ps
module fsc_drive_model (
	input wire logic [1:0] step_out, // Step pulses
	input wire logic [1:0] dir_out, // Step direction
	output logic [1:0] drv_track0 // Head on track zero
);
	int pos [2] = '{0, 0};
	for (genvar i = 0; i < 2; i++) begin : g_drv
		// Move on the trailing edge, direction is settled by then
		always @(negedge step_out[i]) begin
			pos[i] = dir_out[i] ? pos[i] + 1 : (pos[i] > 0 ? pos[i] - 1 : 0);
		end
		assign drv_track0[i] = pos[i] == 0;
	end
endmodule

// ---- verif/fsc_seek_config_properties.sv ----
`timescale 1ns/1ps
module fsc_chk import fsc_pkg::*; #(
	parameter logic [7:0] VERSION_ID = 8'h5A
) (
	input wire logic clock, // Clock
	input wire logic sys_rst, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Write
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [1:0] step_out, // Steps
	input wire logic [1:0] dir_out, // Direction
	input wire logic head_load, // Head load
	input wire logic rw_go, // Data start
	input wire logic dma_request_pin, // DMA request
	input wire logic request_for_master, // Host request
	input wire logic [5:0] gap2_length // Gap2 bytes
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic rd_ok;
	assign rd_ok = pready && !pwrite && !pslverr;
	chk_sense_cause: assert property (rd_ok && paddr == ADDR_SENSE |->
		(prdata[7:0] == 8'h80 || (prdata[7:6] == CODE_POLL) != prdata[SBZ_SEEK_END_BIT]))
		else $error("bad cause code");
	chk_head_zero: assert property (rd_ok && paddr == ADDR_SENSE |-> !prdata[SBZ_HEAD_BIT])
		else $error("head bit set");
	chk_status_now: assert property (psel && !penable && !pwrite && paddr == ADDR_DRV_STAT
		|=> pready && !pslverr) else $error("drive status delayed");
	chk_step_width: assert property ($rose(step_out[0]) |=> step_out[0] [*8])
		else $error("step pulse short");
	chk_dir_steady: assert property (step_out[1] && $past(step_out[1]) |-> $stable(dir_out[1]))
		else $error("direction moved in pulse");
	chk_one_path: assert property (!(dma_request_pin && request_for_master))
		else $error("both request paths");
	chk_load_first: assert property (rw_go |-> head_load && $past(head_load))
		else $error("go without head load");
	chk_gap_long: assert property (pready && pwrite && paddr == ADDR_PERP && pwdata[1:0] == 2'h3
		|-> ##[1:3] gap2_length == GAP2_PERP_1M) else $error("gap2 not long");
	chk_reset_conv: assert property ($fell(sys_rst) |-> gap2_length == GAP2_CONV)
		else $error("gap2 not conventional");
	chk_version_id: assert property (rd_ok && paddr == ADDR_VERSION |-> prdata[7:0] == VERSION_ID)
		else $error("wrong version byte");
	cover property (rd_ok && paddr == ADDR_SENSE && prdata[SBZ_SEEK_END_BIT]);
	cover property ($rose(step_out[1]));
	cover property (rw_go);
endmodule
bind fsc_seek_config fsc_chk #(.VERSION_ID(VERSION_ID)) u_chk (.*);

// ---- verif/fsc_seek_config_test.sv ----
`timescale 1ns/1ps
module fsc_seek_config_test import fsc_pkg::*;;
	logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic rw_start = 0, rw_drive = 0, rw_end = 0, err, no_dma;
	logic [7:0] paddr = 0, rw_cylinder = 0, tg, c;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [1:0] drv_write_protect = 0, drv_ready = 0, drv_two_side = 0;
	logic [1:0] drv_track0, step_out, dir_out;
	logic [4:0] fifo_level = 0;
	logic [5:0] gap2_length;
	logic pready, pslverr, head_load, rw_go, dma_request_pin, request_for_master, interrupt_pin;
	int miscompares = 0, samples_checked = 0, seed = 32'h98cd795e, t;
	always #4 clock = ~clock;
	fsc_seek_config #(.UNIT_CYCLES(10)) dut (.*);
	fsc_drive_model u_drv (.*);
	task automatic wrap_up;
		if (miscompares == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic cond(input int s);
		return s == 0 ? interrupt_pin : s == 1 ? rw_go : !head_load;
	endfunction
	task automatic waitc(input int s, input int lim);
		int n = 0;
		@(posedge clock);
		while (cond(s) !== 1'b1 && n < lim) begin
			@(posedge clock);
			n++;
		end
		if (n == lim) begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n == 20) begin
			miscompares++;
			wrap_up();
		end
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask
	function automatic logic [31:0] pw(input logic [1:0] op, input logic dr, dir, input logic [7:0] v);
		return {17'h0, dir, op, 3'h0, dr, v};
	endfunction
	function automatic logic [7:0] st(input logic [1:0] cd, input logic sk, eq, dr);
		return {cd, sk, eq, 3'h0, dr};
	endfunction
	initial begin
		t = $random(seed);
		no_dma = t[5];
		tg = 8'(8 + t[4:0]);
		c = 8'(258 - tg);
		{drv_write_protect, drv_ready, drv_two_side} <= 6'($random(seed));
		fifo_level <= 5'(1 + t[9:6]);
		repeat (16) @(posedge clock);
		sys_rst <= 0;
		repeat (4) @(posedge clock);
		check(interrupt_pin, 1);
		apb(0, ADDR_SENSE, 0);
		check(rd[7:0], st(CODE_POLL, 0, 0, 0));
		@(posedge clock);
		check(interrupt_pin, 0);
		apb(0, ADDR_CONFIG, 0);
		check(rd, 32'h0000_0002);
		apb(1, ADDR_CONFIG, {16'h0, tg, 8'hF4});
		apb(0, ADDR_CONFIG, 0);
		check(rd, {16'h0, tg, 8'hF4});
		apb(0, ADDR_PERP, 0);
		check(rd, 32'h0000_1600);
		apb(0, ADDR_VERSION, 0);
		check(rd[7:0], 8'h5A);
		apb(1, ADDR_VERSION, 0);
		check(err, 1);
		apb(0, 8'h20, 0);
		check(err, 1);
		apb(1, ADDR_DRV_STAT, 1);
		apb(0, ADDR_DRV_STAT, 0);
		check(rd[7:0], {1'b0, drv_write_protect[1], drv_ready[1], 1'b1, drv_two_side[1], 3'h1});
		apb(1, ADDR_SPECIFY, {16'h0, no_dma, 7'h01, 8'h1F});
		apb(1, ADDR_RATE, RATE_1M);
		apb(1, ADDR_POSITION, pw(1, 0, 0, tg));
		apb(1, ADDR_POSITION, pw(1, 1, 0, 8'h03));
		waitc(0, 20000);
		apb(1, ADDR_POSITION, pw(1, 1, 0, 8'h05));
		check(err, 1);
		apb(0, ADDR_SENSE, 0);
		check(rd[15:0], {8'h03, st(CODE_NORMAL, 1, 0, 1)});
		waitc(0, 20000);
		apb(0, ADDR_SENSE, 0);
		check(rd[15:0], {tg, st(CODE_NORMAL, 1, 0, 0)});
		u_drv.pos[1] = 100;
		apb(1, ADDR_POSITION, pw(2, 0, 1, c));
		apb(1, ADDR_POSITION, pw(2, 1, 1, 8'h01));
		check(err, 1);
		apb(1, ADDR_POSITION, pw(3, 1, 0, 8'h00));
		check(err, 0);
		waitc(0, 40000);
		apb(0, ADDR_SENSE, 0);
		check(rd[7:0], st(CODE_ABNORMAL, 1, 1, 1));
		check(u_drv.pos[1], 20);
		waitc(0, 40000);
		apb(0, ADDR_SENSE, 0);
		check(rd[15:0], {8'h02, st(CODE_NORMAL, 1, 0, 0)});
		check(u_drv.pos[0], tg + c);
		apb(1, ADDR_POSITION, pw(3, 1, 0, 8'h00));
		waitc(0, 20000);
		apb(0, ADDR_SENSE, 0);
		check(rd[15:0], {8'h00, st(CODE_NORMAL, 1, 0, 1)});
		apb(1, ADDR_POSITION, pw(2, 1, 0, 8'h02));
		waitc(0, 20000);
		apb(0, ADDR_SENSE, 0);
		check(rd[7:0], st(CODE_ABNORMAL, 1, 1, 1));
		for (int m = 0; m < 4; m++) begin
			apb(1, ADDR_PERP, m);
			apb(0, ADDR_PERP, 0);
			check(rd, {10'h0, m == 3 ? 6'h26 : m == 1 ? 6'h13 : 6'h00, 2'h0,
				m == 3 ? 6'h29 : 6'h16, 6'h0, 2'(m)});
			check(gap2_length, m == 3 ? 41 : 22);
		end
		apb(1, ADDR_PERP, 0);
		apb(1, ADDR_CONFIG, 32'h0000_0003);
		rw_cylinder <= 8'h05;
		rw_start <= 1;
		@(posedge clock);
		rw_start <= 0;
		waitc(1, 4000);
		check(u_drv.pos[0], tg + c + 3);
		repeat (3) @(posedge clock);
		check({dma_request_pin, request_for_master, interrupt_pin}, no_dma ? 3'b011 : 3'b100);
		rw_end <= 1;
		@(posedge clock);
		rw_end <= 0;
		repeat (100) @(posedge clock);
		check(head_load, 1);
		waitc(2, 400);
		wrap_up();
	end
endmodule
